// *** rtl/dpc_pkg.sv ***
// package for the datapath control register bank
package dpc_pkg;
  // register indices; the byte address is four times the index
  localparam int DPC_IDX_CTRL_A = 0;
  localparam int DPC_IDX_CTRL_B = 1;
  localparam logic [11:0] DPC_OFF_CTRL_A = 12'(DPC_IDX_CTRL_A * 4);
  localparam logic [11:0] DPC_OFF_CTRL_B = 12'(DPC_IDX_CTRL_B * 4);
  localparam logic [11:0] DPC_OFF_EXT = 12'h008;
  localparam logic [7:0] DPC_RST_CTRL_A = 8'h70;
  localparam logic [7:0] DPC_RST_CTRL_B = 8'h11;
  localparam logic [7:0] DPC_RST_EXT = 8'h00;
  localparam logic [7:0] DPC_MASK_CTRL_B = 8'hF5;
  localparam logic [7:0] DPC_MASK_EXT = 8'h7F;
  localparam int DPC_A_OFFS_CORR = 7;
  localparam int DPC_A_FIFO_ON = 6;
  localparam int DPC_A_FRAME_WRST = 5;
  localparam int DPC_A_SYNC_ON = 4;
  localparam int DPC_A_ALARM_OUT = 3;
  localparam int DPC_A_ALARM_POL = 2;
  localparam int DPC_B_QMC_OFFS = 7;
  localparam int DPC_B_QMC_CORR = 6;
  localparam int DPC_B_FIRST_FILT = 5;
  localparam int DPC_B_SECOND_FILT = 4;
  localparam int DPC_B_PATTERN_CHK = 2;
  localparam int DPC_B_TWOS = 0;
  localparam int DPC_E_SYNC_SEL = 7;

  typedef enum logic [1:0] {
    DPC_MIX_NORMAL = 2'b00,
    DPC_MIX_HALF = 2'b01,
    DPC_MIX_PLUS_Q = 2'b10,
    DPC_MIX_MINUS_Q = 2'b11
  } dpc_mix_type;

  typedef struct packed {
    logic offs_corr_on;
    logic fifo_on;
    logic fifo_bypass;
    logic fifo_wr_reset;
    logic sync_pulse;
    logic alert_oe;
    logic alert_level;
    dpc_mix_type mix_mode;
    logic qmc_offs_on;
    logic qmc_corr_on;
    logic first_interp_filter_on;
    logic second_interp_filter_on;
    logic pattern_chk_on;
    logic twos_format;
  } dpc_ctrl_type;

  typedef struct packed {
    logic [7:0] ctrl_a;
    logic [7:0] ctrl_b;
    logic [7:0] ext;
    logic [2:0] frame_sync;
    logic [2:0] strobe_sync;
    logic [6:0] alarm_sync0;
    logic [6:0] alarm_sync1;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    dpc_ctrl_type ctrl;
  } dpc_state_type;
endpackage

// *** rtl/dpc_regs.sv ***
// datapath control register bank with apb slave
//
// The APB slave port was left to the implementer.
`timescale 1ns/1ps
// Notes on behaviour
// - first register at 0x00 resets 0x70
// - second register at 0x04 resets 0x11
// - bit a6 enables fifo, else bypass
// - bit a5: packet strobe resets write pointer
// - bit a4: strobe used as multi-device sync
// - separate select bit picks sync source
// - bit a3 drives alert pin as output
// - alert pin governed by alarm mask
// - bit a2 alert polarity, 1 active high
// - bits a1:0 select mixer mode
// - bit a7 converter offset correction, reset 0
// - bit b7 quadrature offset correction
// - bit b6 quadrature phase gain correction
// - bit b5 first filter, 2x interpolation
// - bit b4 second filter, 4x, reset 1
// - bit b2 runs pattern checker
// - bit b0 twos complement, else offset binary
// - masked alarm never asserts alert pin
module dpc_regs
  import dpc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic packet_start_strobe,
  input wire logic output_timing_strobe,
  input wire logic [6:0] alarm_events,
  output logic alert_serial_out_pin_o,
  output logic alert_serial_out_pin_oe,
  output dpc_ctrl_type ctrl
);

  dpc_state_type cur_ff;
  dpc_state_type nxt_cur;

  function automatic logic [7:0] dpc_merge(input logic [7:0] old, input logic [31:0] wd,
                                           input logic [3:0] strb, input logic [7:0] msk);
    dpc_merge = (strb[0] ? wd[7:0] : old) & msk;
  endfunction

  logic setup;
  logic access_ok;
  logic wr;
  logic alarm_any;
  assign setup = psel && !penable;
  assign access_ok = (paddr == DPC_OFF_CTRL_A) || (paddr == DPC_OFF_CTRL_B)
                     || (paddr == DPC_OFF_EXT);
  // write lands at the edge that completes the access phase
  assign wr = psel && penable && cur_ff.pready && pwrite && access_ok;
  assign alarm_any = |(cur_ff.alarm_sync1 & ~cur_ff.ext[6:0]);

  always_comb begin
    logic [7:0] a;
    logic [7:0] b;
    logic sel_strobe;
    logic frm_edge;
    logic ost_edge;
    a = cur_ff.ctrl_a;
    b = cur_ff.ctrl_b;
    sel_strobe = cur_ff.ext[DPC_E_SYNC_SEL];
    // edge taken from second and third flops only
    frm_edge = cur_ff.frame_sync[1] && !cur_ff.frame_sync[0];
    ost_edge = cur_ff.strobe_sync[1] && !cur_ff.strobe_sync[0];
    nxt_cur = cur_ff;
    nxt_cur.frame_sync = {packet_start_strobe, cur_ff.frame_sync[2:1]};
    nxt_cur.strobe_sync = {output_timing_strobe, cur_ff.strobe_sync[2:1]};
    nxt_cur.alarm_sync0 = alarm_events;
    nxt_cur.alarm_sync1 = cur_ff.alarm_sync0;
    nxt_cur.pready = setup;
    nxt_cur.pslverr = setup && !access_ok;
    nxt_cur.prdata = 32'h0000_0000;
    if (setup && !pwrite) begin
      unique case (paddr)
        DPC_OFF_CTRL_A: nxt_cur.prdata = {24'h00_0000, a};
        DPC_OFF_CTRL_B: nxt_cur.prdata = {24'h00_0000, b};
        DPC_OFF_EXT: nxt_cur.prdata = {24'h00_0000, cur_ff.ext};
        default: nxt_cur.prdata = 32'h0000_0000;
      endcase
    end
    if (wr) begin
      unique case (paddr)
        DPC_OFF_CTRL_A: nxt_cur.ctrl_a = dpc_merge(a, pwdata, pstrb, 8'hFF);
        DPC_OFF_CTRL_B: nxt_cur.ctrl_b = dpc_merge(b, pwdata, pstrb, DPC_MASK_CTRL_B);
        default: nxt_cur.ext = dpc_merge(cur_ff.ext, pwdata, pstrb, DPC_MASK_EXT | 8'h80);
      endcase
    end
    nxt_cur.ctrl.offs_corr_on = a[DPC_A_OFFS_CORR];
    nxt_cur.ctrl.fifo_on = a[DPC_A_FIFO_ON];
    nxt_cur.ctrl.fifo_bypass = !a[DPC_A_FIFO_ON];
    nxt_cur.ctrl.fifo_wr_reset = a[DPC_A_FRAME_WRST] && frm_edge;
    nxt_cur.ctrl.sync_pulse = a[DPC_A_SYNC_ON] && (sel_strobe ? ost_edge : frm_edge);
    nxt_cur.ctrl.alert_oe = a[DPC_A_ALARM_OUT];
    nxt_cur.ctrl.alert_level = a[DPC_A_ALARM_POL] ? alarm_any : !alarm_any;
    nxt_cur.ctrl.mix_mode = dpc_mix_type'(a[1:0]);
    nxt_cur.ctrl.qmc_offs_on = b[DPC_B_QMC_OFFS];
    nxt_cur.ctrl.qmc_corr_on = b[DPC_B_QMC_CORR];
    nxt_cur.ctrl.first_interp_filter_on = b[DPC_B_FIRST_FILT];
    nxt_cur.ctrl.second_interp_filter_on = b[DPC_B_SECOND_FILT];
    nxt_cur.ctrl.pattern_chk_on = b[DPC_B_PATTERN_CHK];
    nxt_cur.ctrl.twos_format = b[DPC_B_TWOS];
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cur_ff <= '0;
      cur_ff.ctrl_a <= DPC_RST_CTRL_A;
      cur_ff.ctrl_b <= DPC_RST_CTRL_B;
      cur_ff.ext <= DPC_RST_EXT;
      cur_ff.ctrl.fifo_on <= 1'b1;
      cur_ff.ctrl.alert_level <= 1'b1;
      cur_ff.ctrl.first_interp_filter_on <= 1'b0;
      cur_ff.ctrl.second_interp_filter_on <= 1'b1;
      cur_ff.ctrl.twos_format <= 1'b1;
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  assign prdata = cur_ff.prdata;
  assign pready = cur_ff.pready;
  assign pslverr = cur_ff.pslverr;
  assign ctrl = cur_ff.ctrl;
  assign alert_serial_out_pin_o = cur_ff.ctrl.alert_level;
  assign alert_serial_out_pin_oe = cur_ff.ctrl.alert_oe;

  reset_a_value_a: assert property (@(posedge pclk)
    $rose(presetn) |-> cur_ff.ctrl_a == DPC_RST_CTRL_A)
    else $error("first register reset value wrong");
  reset_b_value_a: assert property (@(posedge pclk)
    $rose(presetn) |-> cur_ff.ctrl_b == DPC_RST_CTRL_B)
    else $error("second register reset value wrong");
  write_a_lands_a: assert property (@(posedge pclk) disable iff (!presetn)
    (wr && paddr == DPC_OFF_CTRL_A && pstrb[0]) |=> cur_ff.ctrl_a == $past(pwdata[7:0]))
    else $error("write to first register lost");
  fifo_bypass_a: assert property (@(posedge pclk) disable iff (!presetn)
    ##1 ctrl.fifo_bypass == !$past(cur_ff.ctrl_a[6]))
    else $error("fifo bypass mismatch");
  frame_reset_a: assert property (@(posedge pclk) disable iff (!presetn)
    (!packet_start_strobe && cur_ff.ctrl_a[5]) ##1 (packet_start_strobe && cur_ff.ctrl_a[5])
    ##1 cur_ff.ctrl_a[5] ##1 cur_ff.ctrl_a[5] |-> ##1 ctrl.fifo_wr_reset)
    else $error("frame write reset missing");
  reserved_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
    (cur_ff.ctrl_b[3] == 1'b0) && (cur_ff.ctrl_b[1] == 1'b0))
    else $error("reserved bit set");
  alert_dir_a: assert property (@(posedge pclk) disable iff (!presetn)
    ##1 alert_serial_out_pin_oe == $past(cur_ff.ctrl_a[3]))
    else $error("alert direction wrong");
  mask_blocks_a: assert property (@(posedge pclk) disable iff (!presetn)
    (cur_ff.ext[6:0] == 7'h7F && $stable(cur_ff.ext)) |=> alert_serial_out_pin_o
      == !cur_ff.ctrl_a[2] || $changed(cur_ff.ctrl_a))
    else $error("masked alarm reached pin");
  pready_timing_a: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && !penable) |=> pready)
    else $error("pready late");
  write_cov_c: cover property (@(posedge pclk) wr && paddr == DPC_OFF_CTRL_B);
  sync_cov_c: cover property (@(posedge pclk) ctrl.sync_pulse);
  offs_corr_a: assert property (@(posedge pclk) disable iff (!presetn)
    ##1 ctrl.offs_corr_on == $past(cur_ff.ctrl_a[DPC_A_OFFS_CORR]))
    else $error("offset correction enable wrong");
  fifo_on_a: assert property (@(posedge pclk) disable iff (!presetn)
    ##1 ctrl.fifo_on == $past(cur_ff.ctrl_a[DPC_A_FIFO_ON]))
    else $error("fifo enable wrong");
  mix_mode_a: assert property (@(posedge pclk) disable iff (!presetn)
    ##1 ctrl.mix_mode == $past(cur_ff.ctrl_a[1:0]))
    else $error("mixer mode wrong");
  frame_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
    ctrl.fifo_wr_reset |-> $past(cur_ff.ctrl_a[DPC_A_FRAME_WRST]))
    else $error("write reset while disabled");
  sync_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
    ctrl.sync_pulse |-> $past(cur_ff.ctrl_a[DPC_A_SYNC_ON]))
    else $error("sync pulse while disabled");
  frame_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
    ctrl.fifo_wr_reset |=> !ctrl.fifo_wr_reset)
    else $error("write reset pulse too long");
  qmc_offs_a: assert property (@(posedge pclk) disable iff (!presetn)
    ##1 ctrl.qmc_offs_on == $past(cur_ff.ctrl_b[DPC_B_QMC_OFFS]))
    else $error("quadrature offset enable wrong");
  qmc_corr_a: assert property (@(posedge pclk) disable iff (!presetn)
    ##1 ctrl.qmc_corr_on == $past(cur_ff.ctrl_b[DPC_B_QMC_CORR]))
    else $error("phase gain enable wrong");
  first_filt_a: assert property (@(posedge pclk) disable iff (!presetn)
    ##1 ctrl.first_interp_filter_on == $past(cur_ff.ctrl_b[DPC_B_FIRST_FILT]))
    else $error("first filter enable wrong");
  second_filt_a: assert property (@(posedge pclk) disable iff (!presetn)
    ##1 ctrl.second_interp_filter_on == $past(cur_ff.ctrl_b[DPC_B_SECOND_FILT]))
    else $error("second filter enable wrong");
  pattern_chk_a: assert property (@(posedge pclk) disable iff (!presetn)
    ##1 ctrl.pattern_chk_on == $past(cur_ff.ctrl_b[DPC_B_PATTERN_CHK]))
    else $error("pattern checker enable wrong");
  twos_format_a: assert property (@(posedge pclk) disable iff (!presetn)
    ##1 ctrl.twos_format == $past(cur_ff.ctrl_b[DPC_B_TWOS]))
    else $error("number format wrong");
  alert_idle_a: assert property (@(posedge pclk) disable iff (!presetn)
    (cur_ff.alarm_sync1 == 7'h00 && $stable(cur_ff.ctrl_a)) |=>
      alert_serial_out_pin_o == !cur_ff.ctrl_a[DPC_A_ALARM_POL] || $changed(cur_ff.ctrl_a))
    else $error("alert idle level wrong");
  unmapped_wr_a: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && penable && pwrite && pready && !access_ok) |=>
      $stable(cur_ff.ctrl_a) && $stable(cur_ff.ctrl_b) && $stable(cur_ff.ext))
    else $error("unmapped write changed a register");
  pready_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
    pready |=> !pready)
    else $error("pready held too long");
  pslverr_with_ready_a: assert property (@(posedge pclk) disable iff (!presetn)
    pslverr |-> pready)
    else $error("pslverr without pready");
  read_upper_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
    prdata[31:8] == 24'h00_0000)
    else $error("read data upper bits set");
  err_cov_c: cover property (@(posedge pclk) pslverr);
  frame_cov_c: cover property (@(posedge pclk) ctrl.fifo_wr_reset);
  alert_cov_c: cover property (@(posedge pclk) alert_serial_out_pin_oe && !alert_serial_out_pin_o);
endmodule // dpc_regs

// *** tb/test_dpc_regs.sv ***
// self-checking bench for the datapath control register bank
`timescale 1ns/1ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin n_fail++; \
  $display("ERROR %0t got %h want %h", $time, (a), (b)); end end
module test_dpc_regs;
  import dpc_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'hF;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic pkt = 1'b0;
  logic ots = 1'b0;
  logic [6:0] alarm = 7'h00;
  logic pin_o;
  logic pin_oe;
  dpc_ctrl_type ctrl;
  int n_fail = 0;
  int samples_checked = 0;
  int n_fr;
  int n_sy;
  logic [31:0] rd;
  logic err;
  always #5 pclk = ~pclk;
  dpc_regs uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .packet_start_strobe(pkt),
    .output_timing_strobe(ots), .alarm_events(alarm), .alert_serial_out_pin_o(pin_o),
    .alert_serial_out_pin_oe(pin_oe), .ctrl(ctrl));
  // one apb transfer, held until pready is seen high
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d,
                     input logic [3:0] s);
    int t = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      t++;
    end while (pready !== 1'b1 && t < 20);
    if (pready !== 1'b1) begin
      n_fail++;
      $display("ERROR %0t no pready", $time);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    repeat (2) @(negedge pclk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    apb(1'b1, a, d, 4'hF);
  endtask
  task automatic rchk(input logic [11:0] a, input logic [7:0] e, input logic ee);
    apb(1'b0, a, 8'h00, 4'hF);
    `CHK(rd, {24'h0, e})
    `CHK(err, ee)
  endtask
  // raise one strobe and count the control pulses that follow
  task automatic fchk(input logic src, input int efr, input int esy);
    n_fr = 0;
    n_sy = 0;
    @(posedge pclk);
    if (src) ots <= 1'b1;
    else pkt <= 1'b1;
    repeat (10) begin
      @(negedge pclk);
      n_fr += (ctrl.fifo_wr_reset === 1'b1);
      n_sy += (ctrl.sync_pulse === 1'b1);
    end
    @(posedge pclk);
    ots <= 1'b0;
    pkt <= 1'b0;
    repeat (4) @(posedge pclk);
    `CHK(n_fr, efr)
    `CHK(n_sy, esy)
  endtask
  task automatic achk(input logic [6:0] ev, input logic e);
    @(posedge pclk);
    alarm <= ev;
    repeat (6) @(negedge pclk);
    `CHK(pin_o, e)
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    #100000;
    n_fail++;
    close_out;
  end
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    rchk(DPC_OFF_CTRL_A, 8'h70, 1'b0);
    rchk(DPC_OFF_CTRL_B, 8'h11, 1'b0);
    rchk(DPC_OFF_EXT, 8'h00, 1'b0);
    `CHK({ctrl.fifo_on, ctrl.fifo_bypass, ctrl.offs_corr_on}, 3'b100)
    `CHK({ctrl.qmc_corr_on, ctrl.second_interp_filter_on, ctrl.twos_format}, 3'b011)
    `CHK(pin_oe, 1'b0)
    $display("test reset values done");
    for (int m = 0; m < 4; m++) begin
      wr(DPC_OFF_CTRL_A, 8'h80 | 8'(m));
      `CHK(ctrl.mix_mode, dpc_mix_type'(m))
      `CHK({ctrl.fifo_on, ctrl.fifo_bypass, ctrl.offs_corr_on}, 3'b011)
    end
    $display("test control a done");
    apb(1'b1, DPC_OFF_CTRL_B, 8'hFF, 4'hE);
    rchk(DPC_OFF_CTRL_B, 8'h11, 1'b0);
    wr(DPC_OFF_CTRL_B, 8'hFF);
    rchk(DPC_OFF_CTRL_B, 8'hF5, 1'b0);
    `CHK({ctrl.qmc_offs_on, ctrl.qmc_corr_on, ctrl.first_interp_filter_on}, 3'b111)
    `CHK({ctrl.pattern_chk_on, ctrl.twos_format}, 2'b11)
    wr(DPC_OFF_CTRL_B, 8'h00);
    `CHK({ctrl.qmc_offs_on, ctrl.first_interp_filter_on, ctrl.twos_format}, 3'b000)
    wr(12'h00C, 8'hFF);
    rchk(12'h00C, 8'h00, 1'b1);
    $display("test control b done");
    wr(DPC_OFF_CTRL_A, 8'h08);
    `CHK(pin_oe, 1'b1)
    achk(7'h01, 1'b0);
    wr(DPC_OFF_EXT, 8'h01);
    achk(7'h01, 1'b1);
    achk(7'h40, 1'b0);
    wr(DPC_OFF_CTRL_A, 8'h0C);
    achk(7'h40, 1'b1);
    achk(7'h00, 1'b0);
    $display("test alarm pin done");
    wr(DPC_OFF_CTRL_A, 8'h20);
    fchk(1'b0, 1, 0);
    wr(DPC_OFF_CTRL_A, 8'h10);
    fchk(1'b0, 0, 1);
    fchk(1'b1, 0, 0);
    wr(DPC_OFF_EXT, 8'h80);
    fchk(1'b1, 0, 1);
    fchk(1'b0, 0, 0);
    $display("test strobes done");
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rchk(DPC_OFF_CTRL_A, 8'h70, 1'b0);
    rchk(DPC_OFF_EXT, 8'h00, 1'b0);
    $display("test second reset done");
    close_out;
  end
endmodule // test_dpc_regs
